// *** common/tcc_pkg.sv ***
/*
  Package for the capture/compare/gated timer: register offsets, field
  positions, reset values, mode codes and the control register layout.
  Assumes a single clock domain and an APB slave with 32-bit data.
*/
package tcc_pkg;

  localparam logic [7:0]  TCC_OFS_COUNT   = 8'h00;
  localparam logic [7:0]  TCC_OFS_COMPARE = 8'h04;
  localparam logic [7:0]  TCC_OFS_CAPTURE = 8'h08;
  localparam logic [7:0]  TCC_OFS_FLAG    = 8'h0C;
  localparam logic [7:0]  TCC_OFS_CONTROL = 8'h10;
  localparam logic [7:0]  TCC_OFS_INTEN   = 8'h14;

  localparam int          TCC_BIT_MODE_LO = 0;
  localparam int          TCC_BIT_PRES_LO = 3;
  localparam int          TCC_BIT_POL     = 6;
  localparam int          TCC_BIT_EN      = 7;
  localparam int          TCC_BIT_PRES_HI = 8;
  localparam int          TCC_BIT_OUT_EN  = 9;
  localparam int          TCC_BIT_NOOP    = 12;

  localparam logic [31:0] TCC_RST_COUNT   = 32'h0000_0000;
  localparam logic [31:0] TCC_RST_COMPARE = 32'h0000_0000;
  localparam logic [31:0] TCC_RST_CAPTURE = 32'h0000_0000;
  localparam logic [31:0] TCC_RST_CONTROL = 32'h0000_1000;
  localparam logic [31:0] TCC_RELOAD_ONE  = 32'h0000_0001;
  localparam logic [31:0] TCC_RELOAD_ZERO = 32'h0000_0000;
  localparam logic [31:0] TCC_CONTROL_WMASK = 32'h0000_03FF;
  localparam logic [3:0]  TCC_PRES_MAX    = 4'hC;

  typedef enum logic [2:0] {
    TCC_MODE_ONESHOT = 3'b000,
    TCC_MODE_CONT    = 3'b001,
    TCC_MODE_COUNTER = 3'b010,
    TCC_MODE_PWM     = 3'b011,
    TCC_MODE_CAPTURE = 3'b100,
    TCC_MODE_COMPARE = 3'b101,
    TCC_MODE_GATED   = 3'b110,
    TCC_MODE_CAPCMP  = 3'b111
  } tcc_mode_t;

  typedef struct packed {
    logic       out_en;
    logic       prescale_high_bit;
    logic       enable;
    logic       polarity;
    logic [2:0] prescale_low;
    tcc_mode_t  mode;
  } tcc_ctrl_t;

endpackage

// *** src/tcc_timer.sv ***
/*
  Timer with capture, compare, gated and capture/compare modes, reached
  over APB. Assumes timer_pin_in is synchronous-capable but is still
  resynchronised here; APB master follows the usual setup/access order.
*/
// Behaviour
// - Mode code 4 selects capture; software sets it while disabled.
// - Capture edge copies counter into capture register and sets the flag.
// - Capture in capture mode never stops or reloads the counter.
// - Capture mode: counter equal to compare reloads to one and sets flag.
// - Capture registers on the count tick after the selected pin transition.
// - Software counter value only seeds the first period; reloads give one, except in compare mode, which reloads zero.
// - Mode code 5 selects compare mode, a 32-bit period timer.
// - Compare mode period end sets the counter to zero.
// - Compare period end toggles pin if output enabled and sets flag.
// - Compare period ends on the count tick after the match cycle.
// - Mode code 6 selects gated mode; pin acts as input.
// - Gated mode counts only while pin is at the active level.
// - Gated mode match reloads counter to one and sets flag.
// - Mode code 7 selects capture/compare; pin acts as input.
// - Capture/compare idles until first selected edge; that edge sets no flag.
// - Polarity zero selects rising edge, one falling, in capture/compare.
// - Later edges capture, set flag and reload the counter to one.
// - Without capture, match sets flag on the next count tick and reloads to one.
// - Interrupt request rises only when the flag is set and enabled.
// - Four-bit prescale code 0 to 12 divides by powers of two.
// - Flag stays set until any write to its bit clears it.
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int PRES_W = 12
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_pin_in,
  output logic             timer_pin_out,
  output logic             timer_pin_oe,
  output logic             timer_irq
);

  logic [31:0] timer_counter_value_r;
  logic [31:0] period_compare_value_r;
  logic [31:0] capture_or_duty_value_r;
  logic        timer_event_flag_r;
  tcc_ctrl_t   timer_control_r;
  logic        irq_enable_r;
  logic [PRES_W-1:0] pres_cnt_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        pin_prev_r;
  logic        started_r;
  logic        pin_level_r;

  logic        wr_en;
  logic        rd_en;
  logic        tick;
  logic [3:0]  pres_code;
  logic        pin_edge;
  logic        pin_active;
  logic        cnt_match;
  logic        ev_period;
  logic        ev_capture;
  logic        do_reload_one;
  logic        do_reload_zero;
  logic        do_count;
  logic        do_start;
  logic        cnt_written;

  // Register write/read strobes in the access phase
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  function automatic logic [PRES_W-1:0] pres_mask(input logic [3:0] code);
    logic [PRES_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRES_W; i++) begin
      if (i < int'(code)) begin
        m[i] = 1'b1;
      end
    end
    pres_mask = m;
  endfunction

  assign cnt_written = wr_en && addr_hit(paddr, TCC_OFS_COUNT);

  // Count tick every 2^code clocks; reserved codes fall back to the slowest
  assign pres_code = (({timer_control_r.prescale_high_bit, timer_control_r.prescale_low}) > TCC_PRES_MAX)
                     ? TCC_PRES_MAX : {timer_control_r.prescale_high_bit, timer_control_r.prescale_low};
  assign tick = timer_control_r.enable && ((pres_cnt_r & pres_mask(pres_code)) == pres_mask(pres_code));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pres_cnt_r <= '0;
    end else if (!timer_control_r.enable) begin
      pres_cnt_r <= '0;
    end else if (tick) begin
      pres_cnt_r <= '0;
    end else begin
      pres_cnt_r <= pres_cnt_r + 1'b1;
    end
  end

  // Two-flop synchroniser; only the second stage feeds edge logic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= timer_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Previous level sampled at count ticks, so edges are seen per tick
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_prev_r <= 1'b0;
    end else if (tick || !timer_control_r.enable) begin
      pin_prev_r <= pin_s2_r;
    end
  end

  // Capture mode: edge into active level; capture/compare: pol 0 rising, 1 falling
  assign pin_edge   = timer_control_r.polarity ? (pin_prev_r && !pin_s2_r)
                                               : (!pin_prev_r && pin_s2_r);
  assign pin_active = pin_s2_r ^ timer_control_r.polarity;
  assign cnt_match  = (timer_counter_value_r == period_compare_value_r);

  always_comb begin
    ev_period      = 1'b0;
    ev_capture     = 1'b0;
    do_reload_one  = 1'b0;
    do_reload_zero = 1'b0;
    do_count       = 1'b0;
    do_start       = 1'b0;
    // Period ends on the tick that leaves the match value, so it lasts compare - start + 1 ticks
    if (tick) begin
      unique case (timer_control_r.mode)
        TCC_MODE_CAPTURE: begin
          ev_capture    = pin_edge;
          ev_period     = cnt_match;
          do_reload_one = cnt_match;
          do_count      = 1'b1;
        end
        TCC_MODE_COMPARE: begin
          ev_period      = cnt_match;
          do_reload_zero = cnt_match;
          do_count       = 1'b1;
        end
        TCC_MODE_GATED: begin
          ev_period     = cnt_match;
          do_reload_one = cnt_match;
          do_count      = pin_active;
        end
        TCC_MODE_CAPCMP: begin
          if (!started_r) begin
            do_start = pin_edge;
          end else begin
            ev_capture    = pin_edge;
            ev_period     = cnt_match && !pin_edge;
            do_reload_one = pin_edge || cnt_match;
            do_count      = 1'b1;
          end
        end
        default: begin
          do_count = 1'b0;
        end
      endcase
    end
  end

  // Capture/compare start latch, cleared on disable
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      started_r <= 1'b0;
    end else if (!timer_control_r.enable) begin
      started_r <= 1'b0;
    end else if (do_start) begin
      started_r <= 1'b1;
    end
  end

  // Counter; software writes only seed the first period
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_counter_value_r <= TCC_RST_COUNT;
    end else if (cnt_written) begin
      timer_counter_value_r <= pwdata;
    end else if (do_reload_zero) begin
      timer_counter_value_r <= TCC_RELOAD_ZERO;
    end else if (do_reload_one) begin
      timer_counter_value_r <= TCC_RELOAD_ONE;
    end else if (do_count) begin
      timer_counter_value_r <= timer_counter_value_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      capture_or_duty_value_r <= TCC_RST_CAPTURE;
    end else if (ev_capture) begin
      capture_or_duty_value_r <= timer_counter_value_r;
    end else if (wr_en && addr_hit(paddr, TCC_OFS_CAPTURE)) begin
      capture_or_duty_value_r <= pwdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      period_compare_value_r <= TCC_RST_COMPARE;
    end else if (wr_en && addr_hit(paddr, TCC_OFS_COMPARE)) begin
      period_compare_value_r <= pwdata;
    end
  end

  // Settings steer the block; software is trusted to disable first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_control_r <= tcc_ctrl_t'(TCC_RST_CONTROL[9:0]);
      irq_enable_r    <= 1'b0;
    end else if (wr_en && addr_hit(paddr, TCC_OFS_CONTROL)) begin
      timer_control_r <= tcc_ctrl_t'(pwdata[9:0]);
    end else if (wr_en && addr_hit(paddr, TCC_OFS_INTEN)) begin
      irq_enable_r <= pwdata[0];
    end
  end

  // Set wins over a same-cycle software clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_event_flag_r <= 1'b0;
    end else if (ev_period || ev_capture) begin
      timer_event_flag_r <= 1'b1;
    end else if (wr_en && addr_hit(paddr, TCC_OFS_FLAG)) begin
      timer_event_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= timer_event_flag_r && irq_enable_r;
    end
  end

  // Compare-mode output toggles at each period end, idles at polarity
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_level_r <= 1'b0;
    end else if (!timer_control_r.enable) begin
      pin_level_r <= 1'b0;
    end else if (ev_period && timer_control_r.mode == TCC_MODE_COMPARE) begin
      pin_level_r <= !pin_level_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_pin_out <= 1'b0;
      timer_pin_oe  <= 1'b0;
    end else begin
      timer_pin_out <= pin_level_r ^ timer_control_r.polarity;
      timer_pin_oe  <= timer_control_r.out_en && (timer_control_r.mode == TCC_MODE_COMPARE);
    end
  end

  // Zero-wait APB; unmapped addresses read zero and flag an error
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(addr_hit(paddr, TCC_OFS_COUNT) || addr_hit(paddr, TCC_OFS_COMPARE)
                 || addr_hit(paddr, TCC_OFS_CAPTURE) || addr_hit(paddr, TCC_OFS_FLAG)
                 || addr_hit(paddr, TCC_OFS_CONTROL) || addr_hit(paddr, TCC_OFS_INTEN));
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          TCC_OFS_COUNT:   prdata <= timer_counter_value_r;
          TCC_OFS_COMPARE: prdata <= period_compare_value_r;
          TCC_OFS_CAPTURE: prdata <= capture_or_duty_value_r;
          TCC_OFS_FLAG:    prdata <= {31'h0000_0000, timer_event_flag_r};
          TCC_OFS_CONTROL: prdata <= {19'h0_0000, 1'b1, 2'b00, timer_control_r};
          TCC_OFS_INTEN:   prdata <= {31'h0000_0000, irq_enable_r};
          default:         prdata <= 32'h0000_0000;
        endcase
      end else if (rd_en) begin
        prdata <= prdata;
      end
    end
  end

endmodule

// *** bench/tcc_timer_checker.sv ***
/*
  Port checker for the timer: APB handshake, decode, irq mask, pin enable.
  Assumes it is bound to tcc_timer, one clock, active-low async reset.
*/
module tcc_timer_checker
  import tcc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_pin_in,
  input wire logic        timer_pin_out,
  input wire logic        timer_pin_oe,
  input wire logic        timer_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic acc;
  logic hit;
  logic oe_w;
  assign acc  = psel && penable;
  assign hit  = paddr inside {TCC_OFS_COUNT, TCC_OFS_COMPARE, TCC_OFS_CAPTURE, TCC_OFS_FLAG,
                              TCC_OFS_CONTROL, TCC_OFS_INTEN};
  assign oe_w = acc && pwrite && paddr == TCC_OFS_CONTROL && pwdata[TCC_BIT_OUT_EN] && pwdata[2:0] == 3'h5;
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_idle: assert property (!psel |=> !pready)
    else $error("pready without setup");
  chk_err_decode: assert property (acc |-> pready && (pslverr == !hit))
    else $error("pslverr does not match decode");
  chk_err_lone: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  chk_read_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_mask: assert property (acc && pwrite && paddr == TCC_OFS_INTEN && !pwdata[0] |=> ##1 !timer_irq)
    else $error("irq still high after masking");
  chk_oe_cause: assert property ($rose(timer_pin_oe) |-> $past(oe_w) || $past(oe_w, 2))
    else $error("pin enable rose without compare output setup");
endmodule

bind tcc_timer tcc_timer_checker tcc_timer_checker_inst (.clock, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .timer_pin_in, .timer_pin_out, .timer_pin_oe, .timer_irq);

// *** bench/tcc_pin_model.sv ***
/*
  External source on the timer pin; follows want promptly or four clocks late.
  Assumes the bench muxes it off the wire while the timer drives the pin.
*/
module tcc_pin_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic want,
  input wire logic slow,
  output logic     level
);
  logic       level_r;
  logic [1:0] age_r;
  assign level = level_r;
  // Slow lag mimics a weak external driver
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      level_r <= 1'b0;
      age_r   <= 2'h0;
    end else if (level_r == want) begin
      age_r <= 2'h0;
    end else if (!slow || age_r == 2'h3) begin
      level_r <= want;
      age_r   <= 2'h0;
    end else begin
      age_r <= age_r + 2'h1;
    end
  end
endmodule

// *** bench/timer_capture_compare_gated_modes_test.sv ***
/*
  Self-checking bench: APB tasks and one task per timer mode scenario.
  Assumes tcc_timer, the bound checker and the pin model are compiled.
*/
module timer_capture_compare_gated_modes_test
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rstn  = 1'b0;
  logic        psel, penable, pwrite, want, slow, drive, err;
  logic        pready, pslverr, pin_in, pin_out, pin_oe, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, a;
  int          errors = 0;
  int          checks = 0;
  int          rolls  = 0;

  always #5 clock = ~clock;
  // Timer owns the wire while its output is enabled
  assign pin_in = pin_oe ? pin_out : drive;
  tcc_pin_model tcc_pin_model_inst (.clock, .rstn, .want, .slow, .level(drive));
  tcc_timer tcc_timer_inst (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timer_pin_in(pin_in), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .timer_irq(irq));

  task complete_run;
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task expect_true(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t, check %0d", $time, checks);
    end
  endtask
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("wrong value at %0t, no pready", $time);
      complete_run;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr32(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task rd32(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0000_0000);
  endtask
  task wait_irq;
    int n;
    for (n = 0; irq !== 1'b1 && n < 300; n++) @(posedge clock);
    if (irq !== 1'b1) begin
      errors++;
      $display("wrong value at %0t, no irq", $time);
      complete_run;
    end
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [3:0] p, input logic pol, en, oe);
    ctl = {22'h0, oe, p[3], en, pol, p[2:0], m};
  endfunction
  task setup(input logic [2:0] m, input logic [3:0] p, input logic pol, oe, input logic [31:0] cnt, cmp);
    wr32(TCC_OFS_CONTROL, ctl(m, p, pol, 1'b0, oe));
    wr32(TCC_OFS_COUNT, cnt);
    wr32(TCC_OFS_COMPARE, cmp);
    wr32(TCC_OFS_FLAG, 32'h0000_0000);
    wr32(TCC_OFS_INTEN, 32'h0000_0001);
    wr32(TCC_OFS_CONTROL, ctl(m, p, pol, 1'b1, oe));
  endtask
  task s_regs;
    rd32(TCC_OFS_CONTROL);
    expect_true(rd === TCC_RST_CONTROL);
    rd32(TCC_OFS_COUNT);
    expect_true(rd === TCC_RST_COUNT);
    rd32(8'h18);
    expect_true(err === 1'b1 && rd === 32'h0000_0000);
    wr32(TCC_OFS_CONTROL, 32'hFFFF_FFFF);
    rd32(TCC_OFS_CONTROL);
    expect_true(rd === (TCC_CONTROL_WMASK | TCC_RST_CONTROL));
  endtask
  task s_compare;
    setup(3'h5, 4'h0, 1'b0, 1'b1, 32'h0, 32'h40);
    wait_irq;
    expect_true(pin_oe === 1'b1 && pin_out === 1'b1);
    rd32(TCC_OFS_COUNT);
    expect_true(rd < 32'h8);
    wr32(TCC_OFS_FLAG, 32'h0000_0000);
    repeat (2) @(posedge clock);
    expect_true(irq === 1'b0);
    wait_irq;
    expect_true(pin_out === 1'b0);
    wr32(TCC_OFS_CONTROL, ctl(3'h5, 4'h0, 1'b0, 1'b0, 1'b1));
    wr32(TCC_OFS_INTEN, 32'h0000_0000);
    repeat (2) @(posedge clock);
    expect_true(irq === 1'b0);
    rd32(TCC_OFS_COUNT);
    a = rd;
    repeat (20) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    expect_true(rd === a);
  endtask
  task s_gated;
    setup(3'h6, 4'h1, 1'b0, 1'b0, 32'h5, 32'h40);
    repeat (20) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    expect_true(rd === 32'h5);
    want <= 1'b1;
    repeat (6) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    a = rd;
    repeat (40) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    expect_true(rd - a inside {[32'h14:32'h17]});
    wait_irq;
    rd32(TCC_OFS_COUNT);
    expect_true(rd < 32'h8);
    want <= 1'b0;
    repeat (6) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    a = rd;
    repeat (20) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    expect_true(rd === a);
  endtask
  task s_capture;
    slow <= 1'b1;
    setup(3'h4, 4'h0, 1'b0, 1'b0, 32'h0, 32'h1000);
    repeat (30) @(posedge clock);
    want <= 1'b1;
    wait_irq;
    rd32(TCC_OFS_CAPTURE);
    a = rd;
    rd32(TCC_OFS_COUNT);
    expect_true(a inside {[32'h1E:32'h2D]});
    expect_true(rd > a);
    setup(3'h4, 4'h0, 1'b0, 1'b0, 32'h0, 32'h20);
    rolls = 0;
    wait_irq;
    rd32(TCC_OFS_CAPTURE);
    expect_true(rd === a);
    rd32(TCC_OFS_COUNT);
    expect_true(rd < 32'h8);
    wr32(TCC_OFS_FLAG, 32'h0000_0000);
    rolls++;
    want <= 1'b0;
    repeat (8) @(posedge clock);
    want <= 1'b1;
    repeat (12) @(posedge clock);
    rd32(TCC_OFS_CAPTURE);
    expect_true(rd inside {[32'h16:32'h1E]} && rolls == 1);
    rolls = 0;
    slow <= 1'b0;
  endtask
  task s_capcmp;
    setup(3'h7, 4'h0, 1'b1, 1'b0, 32'h0, 32'h1000);
    repeat (20) @(posedge clock);
    rd32(TCC_OFS_COUNT);
    expect_true(rd === 32'h0 && irq === 1'b0);
    want <= 1'b0;
    repeat (20) @(posedge clock);
    expect_true(irq === 1'b0);
    want <= 1'b1;
    repeat (20) @(posedge clock);
    expect_true(irq === 1'b0);
    want <= 1'b0;
    wait_irq;
    rd32(TCC_OFS_CAPTURE);
    a = rd;
    rd32(TCC_OFS_COUNT);
    expect_true(a inside {[32'h24:32'h2C]});
    expect_true(rd < a);
    setup(3'h7, 4'h0, 1'b1, 1'b0, 32'h0, 32'h20);
    want <= 1'b1;
    repeat (6) @(posedge clock);
    want <= 1'b0;
    wait_irq;
    rd32(TCC_OFS_CAPTURE);
    expect_true(rd === a);
    rd32(TCC_OFS_COUNT);
    expect_true(rd < 32'h8);
  endtask
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    want    = 1'b0;
    slow    = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    s_regs;
    s_compare;
    s_gated;
    s_capture;
    s_capcmp;
    complete_run;
  end
endmodule
